// ---- src/scp_pkg.sv ----
// Shared constants and carrier types for the serial configuration port.
// Assumes a single 40 MHz system clock; the serial lines are asynchronous pins.
package scp_pkg;
   localparam int CLK_PERIOD_PS   = 25000;
   localparam int SETTLE_NS       = 270;
   // Longest settle time rounds down to whole cycles, never below one
   localparam int SETTLE_CYC_RAW  = (SETTLE_NS * 1000) / CLK_PERIOD_PS;
   localparam int SETTLE_CYCLES   = (SETTLE_CYC_RAW < 1) ? 1 : SETTLE_CYC_RAW;
   localparam int WORD_BITS       = 15;
   localparam int DATA_BITS       = 8;
   localparam int ADDR_BITS       = 4;
   localparam int UNIT_BITS       = 2;
   localparam int NUM_REGS        = 16;
   localparam int NUM_UNITS       = 4;
   // Command word field positions, flag first on the wire
   localparam int RW_POS          = 14;
   localparam int UNIT_LSB        = 12;
   localparam int ADDR_LSB        = 8;
   localparam int DATA_LSB        = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   // Idle pin levels {serial_in, shift_clk, frame_select}: frame select high, the rest low
   localparam logic [2:0] PIN_IDLE  = 3'h1;

   // AXI4-Lite register map (byte addresses)
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h04;
   localparam logic [7:0] OFS_LAST   = 8'h08;
   localparam logic [7:0] OFS_REG0   = 8'h40;
   localparam logic [7:0] OFS_REGEND = 8'h7C;
   localparam int CTRL_UNIT_LSB   = 0;
   localparam int CTRL_SO_EN_POS  = 2;
   localparam logic [1:0] CTRL_UNIT_RESET = 2'h0;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic       rw;
      logic [1:0] unit;
      logic [3:0] addr;
      logic [7:0] data;
   } cmd_word_t;
endpackage : scp_pkg

// ---- src/scp_link_sync.sv ----
// Two-stage synchroniser bank for the serial pins, with edge flags.
// Assumes all inputs are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none
module scp_link_sync #(
   parameter int               WIDTH      = 3,
   parameter logic [WIDTH-1:0] IDLE_LEVEL = '1
) (
   input  wire logic             aclk,      // System clock
   input  wire logic             aresetn,   // Synchronous reset, active low
   input  wire logic [WIDTH-1:0] pin_in,    // Raw pins
   output logic      [WIDTH-1:0] level,     // Synchronised level
   output logic      [WIDTH-1:0] rise,      // One-cycle rising pulse
   output logic      [WIDTH-1:0] fall       // One-cycle falling pulse
);
   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;
   logic [WIDTH-1:0] prev_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Reset to the idle levels so no false edge follows reset
         meta_ff <= IDLE_LEVEL;
         sync_ff <= IDLE_LEVEL;
         prev_ff <= IDLE_LEVEL;
      end else begin
         meta_ff <= pin_in;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
      end
   end

   assign level = sync_ff;
   assign rise  = sync_ff & ~prev_ff;
   assign fall  = ~sync_ff & prev_ff;
endmodule // scp_link_sync
`default_nettype wire

// ---- src/serial_config_port.sv ----
// Serial configuration port: frame-select / shift clock / serial in / serial out
// slave with one 16-entry register bank serving the selected unit, visible over AXI4-Lite.
// Assumes the shift clock is at most about aclk/4 so each edge is seen.
`timescale 1ns/1ps
`default_nettype none
module serial_config_port (
   input  wire logic        aclk,          // 40 MHz system clock
   input  wire logic        aresetn,       // Synchronous reset, active low
   input  wire logic        frame_select,  // Frame select pin, active low
   input  wire logic        shift_clk,     // Serial shift clock pin
   input  wire logic        serial_in,     // Serial data in pin
   output logic             serial_out,    // Serial data out
   output logic             serial_out_en_n, // Output enable for serial_out, active low
   output logic             port_ready,    // High once settle time has passed
   input  wire logic [7:0]  s_axi_awaddr,  // AXI4-Lite write address
   input  wire logic        s_axi_awvalid, // Write address valid
   output logic             s_axi_awready, // Write address ready
   input  wire logic [31:0] s_axi_wdata,   // Write data
   input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
   input  wire logic        s_axi_wvalid,  // Write data valid
   output logic             s_axi_wready,  // Write data ready
   output logic [1:0]       s_axi_bresp,   // Write response
   output logic             s_axi_bvalid,  // Write response valid
   input  wire logic        s_axi_bready,  // Write response ready
   input  wire logic [7:0]  s_axi_araddr,  // Read address
   input  wire logic        s_axi_arvalid, // Read address valid
   output logic             s_axi_arready, // Read address ready
   output logic [31:0]      s_axi_rdata,   // Read data
   output logic [1:0]       s_axi_rresp,   // Read response
   output logic             s_axi_rvalid,  // Read data valid
   input  wire logic        s_axi_rready   // Read data ready
);
   logic [2:0]               pin_level;
   logic [2:0]               pin_rise;
   logic [2:0]               pin_fall;
   logic [14:0]              shift_ff;
   logic [7:0]               out_ff;
   logic [3:0]               last_addr_ff;
   logic [1:0]               last_unit_ff;
   logic [7:0]               bank_ff [scp_pkg::NUM_REGS];
   logic [1:0]               ctrl_unit_ff;
   logic                     ctrl_so_en_ff;
   logic [15:0]              frame_cnt_ff;
   logic [14:0]              last_word_ff;
   logic [3:0]               settle_ff;
   logic                     ready_ff;
   logic                     in_frame_ff;
   logic                     so_ff;
   logic                     so_oe_n_ff;
   logic                     awready_ff;
   logic                     wready_ff;
   logic                     bvalid_ff;
   logic [1:0]               bresp_ff;
   logic [7:0]               aw_ff;
   logic [31:0]              wd_ff;
   logic                     aw_have_ff;
   logic                     w_have_ff;
   logic                     arready_ff;
   logic                     rvalid_ff;
   logic [31:0]              rdata_ff;
   logic [1:0]               rresp_ff;
   scp_pkg::cmd_word_t       cmd;
   logic                     fs_low;
   logic                     sclk_rise;
   logic                     sclk_fall;
   logic                     fs_rise;
   logic                     fs_fall;
   logic                     commit;
   logic                     axi_wr;
   logic                     unit_hit;

   scp_link_sync #(
      .WIDTH      (3),
      .IDLE_LEVEL (scp_pkg::PIN_IDLE)
   ) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .pin_in  ({serial_in, shift_clk, frame_select}),
      .level   (pin_level),
      .rise    (pin_rise),
      .fall    (pin_fall)
   );

   assign fs_low    = ~pin_level[0];
   assign fs_rise   = pin_rise[0];
   assign fs_fall   = pin_fall[0];
   assign sclk_rise = pin_rise[1];
   assign sclk_fall = pin_fall[1];
   assign cmd       = scp_pkg::cmd_word_t'(shift_ff);
   assign commit    = fs_rise & in_frame_ff;
   assign unit_hit  = (cmd.unit == ctrl_unit_ff);

   // Settle counter after reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settle_ff <= 4'h0;
         ready_ff  <= 1'b0;
      end else if (!ready_ff) begin
         settle_ff <= settle_ff + 4'h1;
         ready_ff  <= (settle_ff == 4'(scp_pkg::SETTLE_CYCLES - 1));
      end
   end

   // Frame tracking: frames that begin before settling are ignored
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_frame_ff <= 1'b0;
      end else if (fs_fall && ready_ff) begin
         in_frame_ff <= 1'b1;
      end else if (fs_rise) begin
         in_frame_ff <= 1'b0;
      end
   end

   // Input shifter keeps only the last 15 bits
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shift_ff <= 15'h0000;
      end else if (fs_fall) begin
         shift_ff <= 15'h0000;
      end else if (in_frame_ff && fs_low && sclk_rise) begin
         shift_ff <= {shift_ff[13:0], pin_level[2]};
      end
   end

   // Address latch for readback, updated by reads and writes alike
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         last_addr_ff <= 4'h0;
         last_unit_ff <= 2'h0;
         last_word_ff <= 15'h0000;
         frame_cnt_ff <= 16'h0000;
      end else if (commit) begin
         last_addr_ff <= cmd.addr;
         last_unit_ff <= cmd.unit;
         last_word_ff <= shift_ff;
         frame_cnt_ff <= frame_cnt_ff + 16'h0001;
      end
   end

   // Register bank: serial writes on frame end, bus writes otherwise
   assign axi_wr = aw_have_ff && w_have_ff && !bvalid_ff;
   generate
      for (genvar i = 0; i < scp_pkg::NUM_REGS; i++) begin : g_bank
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               bank_ff[i] <= scp_pkg::REG_RESET;
            end else if (commit && !cmd.rw && unit_hit && cmd.addr == 4'(i)) begin
               bank_ff[i] <= cmd.data;
            end else if (axi_wr && aw_ff[7:6] == 2'h1 && aw_ff[5:2] == 4'(i) && wd_ff[31]) begin
               bank_ff[i] <= wd_ff[7:0];
            end
         end
      end
   endgenerate

   // Serial output: load on frame start, shift on falling shift-clock edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         out_ff     <= 8'h00;
         so_ff      <= 1'b0;
         so_oe_n_ff <= 1'b1;
      end else if (fs_fall && ready_ff) begin
         out_ff     <= (last_unit_ff == ctrl_unit_ff) ? bank_ff[last_addr_ff] : 8'h00;
         so_ff      <= (last_unit_ff == ctrl_unit_ff) ? bank_ff[last_addr_ff][7] : 1'b0;
         so_oe_n_ff <= ~ctrl_so_en_ff;
      end else if (fs_rise) begin
         so_oe_n_ff <= 1'b1;
      end else if (in_frame_ff && sclk_fall) begin
         out_ff <= {out_ff[6:0], 1'b0};
         so_ff  <= out_ff[6];
      end
   end

   // AXI4-Lite write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         aw_ff      <= 8'h00;
         wd_ff      <= 32'h0000_0000;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= scp_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && awready_ff) begin
            aw_ff      <= s_axi_awaddr;
            aw_have_ff <= 1'b1;
            awready_ff <= 1'b0;
         end
         if (s_axi_wvalid && wready_ff) begin
            wd_ff     <= {s_axi_wstrb[0], 23'h000000, s_axi_wdata[7:0]};
            w_have_ff <= 1'b1;
            wready_ff <= 1'b0;
         end
         if (axi_wr) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (aw_ff == scp_pkg::OFS_CTRL || aw_ff[7:6] == 2'h1)
                         ? scp_pkg::RESP_OKAY : scp_pkg::RESP_SLVERR;
         end
         if (bvalid_ff && s_axi_bready) begin
            bvalid_ff  <= 1'b0;
            aw_have_ff <= 1'b0;
            w_have_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
         end
      end
   end

   // Control register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_unit_ff  <= scp_pkg::CTRL_UNIT_RESET;
         ctrl_so_en_ff <= 1'b1;
      end else if (axi_wr && aw_ff == scp_pkg::OFS_CTRL && wd_ff[31]) begin
         ctrl_unit_ff  <= wd_ff[scp_pkg::CTRL_UNIT_LSB +: 2];
         ctrl_so_en_ff <= wd_ff[scp_pkg::CTRL_SO_EN_POS];
      end
   end

   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= scp_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && arready_ff) begin
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b1;
         rresp_ff   <= scp_pkg::RESP_OKAY;
         if (s_axi_araddr == scp_pkg::OFS_CTRL) begin
            rdata_ff <= {29'h0, ctrl_so_en_ff, ctrl_unit_ff};
         end else if (s_axi_araddr == scp_pkg::OFS_STATUS) begin
            rdata_ff <= {frame_cnt_ff, 14'h0000, in_frame_ff, ready_ff};
         end else if (s_axi_araddr == scp_pkg::OFS_LAST) begin
            rdata_ff <= {17'h00000, last_word_ff};
         end else if (s_axi_araddr[7:6] == 2'h1 && s_axi_araddr[1:0] == 2'h0) begin
            rdata_ff <= {24'h000000, bank_ff[s_axi_araddr[5:2]]};
         end else begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= scp_pkg::RESP_SLVERR;
         end
      end else if (rvalid_ff && s_axi_rready) begin
         rvalid_ff  <= 1'b0;
         arready_ff <= 1'b1;
      end
   end

   assign serial_out    = so_ff;
   assign serial_out_en_n = so_oe_n_ff;
   assign port_ready    = ready_ff;
   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

   a_settle_time: assert property (@(posedge aclk) disable iff (!aresetn)
      $rose(ready_ff) |-> $past(settle_ff) == 4'(scp_pkg::SETTLE_CYCLES - 1))
      else $error("settle time wrong");
   a_shift_in_bit: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_frame_ff && fs_low && sclk_rise && !fs_fall) |=> shift_ff[0] == $past(pin_level[2]))
      else $error("serial bit not captured");
   a_keep_last: assert property (@(posedge aclk) disable iff (!aresetn)
      (in_frame_ff && fs_low && sclk_rise && !fs_fall) |=> shift_ff[14:1] == $past(shift_ff[13:0]))
      else $error("shifter lost bits");
   a_write_commit: assert property (@(posedge aclk) disable iff (!aresetn)
      (commit && !cmd.rw && unit_hit) |=> bank_ff[$past(cmd.addr)] == $past(cmd.data))
      else $error("write not committed");
   a_read_nowrite: assert property (@(posedge aclk) disable iff (!aresetn)
      (commit && cmd.rw && !axi_wr) |=> bank_ff[$past(cmd.addr)] == $past(bank_ff[cmd.addr]))
      else $error("read altered register");
   a_addr_latch: assert property (@(posedge aclk) disable iff (!aresetn)
      commit |=> last_addr_ff == $past(cmd.addr))
      else $error("readback address not latched");
   a_msb_first: assert property (@(posedge aclk) disable iff (!aresetn)
      (fs_fall && ready_ff && last_unit_ff == ctrl_unit_ff) |=> so_ff == $past(bank_ff[last_addr_ff][7]))
      else $error("first bit not msb");
   a_out_load: assert property (@(posedge aclk) disable iff (!aresetn)
      (fs_fall && ready_ff && last_unit_ff == ctrl_unit_ff) |=> out_ff == $past(bank_ff[last_addr_ff]))
      else $error("readback not loaded");
   a_oe_off: assert property (@(posedge aclk) disable iff (!aresetn)
      fs_rise |=> so_oe_n_ff)
      else $error("output still enabled");
   c_write: cover property (@(posedge aclk) disable iff (!aresetn) commit && !cmd.rw);
   c_read: cover property (@(posedge aclk) disable iff (!aresetn) commit && cmd.rw);
   c_readback: cover property (@(posedge aclk) disable iff (!aresetn) commit ##[1:200] fs_fall);
endmodule // serial_config_port
`default_nettype wire

// ---- tb/scp_host_model.sv ----
// Host controller model driving the serial configuration lines.
// Assumes aclk is 40 MHz; the shift clock runs at 200 ns and idles low between frames.
`timescale 1ns/1ps
`default_nettype none
module scp_host_model (
   input  wire logic aclk,         // System clock, paces the host
   output var logic  frame_select, // Frame select, active low
   output var logic  shift_clk,    // Shift clock
   output var logic  serial_in,    // Serial data to the port
   input  wire logic serial_out    // Serial data from the port
);
   initial begin
      frame_select = 1'b1;
      shift_clk    = 1'b0;
      serial_in    = 1'b0;
   end

   // Sends the low n bits MSB first and gathers the first eight returned bits
   task automatic frame(input logic [19:0] bits, input int n, output logic [7:0] rx);
      int i;
      rx = 8'h00;
      @(posedge aclk);
      frame_select <= 1'b0;
      repeat (4) @(posedge aclk);
      for (i = n - 1; i >= 0; i--) begin
         shift_clk <= 1'b0;
         serial_in <= bits[i];
         repeat (4) @(posedge aclk);
         shift_clk <= 1'b1;
         repeat (4) @(posedge aclk);
         if (i >= n - 8) rx = {rx[6:0], serial_out};
      end
      shift_clk <= 1'b0;
      serial_in <= ~serial_in;
      repeat (4) @(posedge aclk);
      frame_select <= 1'b1;
      repeat (6) @(posedge aclk);
   endtask
endmodule // scp_host_model
`default_nettype wire

// ---- tb/tb.sv ----
// Self-checking bench: serial frames from the host model, registers over AXI4-Lite.
// Assumes the port answers unit 0 after reset and drives serial_out during frames.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic        frame_select, shift_clk, serial_in, serial_out, serial_out_en_n, port_ready, so_pin;
   logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] rd;
   logic [7:0]  rx;
   int          failures = 0;
   int          checks_done = 0;

   always #12.5 aclk = ~aclk;

   serial_config_port serial_config_port_i (
      .aclk, .aresetn, .frame_select, .shift_clk, .serial_in, .serial_out, .serial_out_en_n, .port_ready,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   // A released serial_out shows the inverse of its last value, so a sample taken while released is caught
   assign so_pin = serial_out_en_n ? ~serial_out : serial_out;
   scp_host_model scp_host_model_i (.aclk, .frame_select, .shift_clk, .serial_in, .serial_out (so_pin));

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic test_done();
      $display("checks_done=%0d failures=%0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata   <= d;
      s_axi_wstrb   <= 4'hF;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic reg_is(input logic [3:0] n, input logic [7:0] exp);
      axi_read(scp_pkg::OFS_REG0 + {2'h0, n, 2'h0}, rd, rsp);
      check("reg", rd, {24'h000000, exp});
   endtask

   function automatic logic [19:0] cw(input logic rw, input logic [1:0] u, input logic [3:0] a,
                                      input logic [7:0] d);
      return {5'h00, rw, u, a, d};
   endfunction

   initial begin
      repeat (50000) @(posedge aclk);
      failures++;
      test_done();
   end

   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      fork
         scp_host_model_i.frame(cw(1'b0, 2'h0, 4'h3, 8'hA5), 15, rx);
         begin
            @(posedge aclk);
            @(negedge aclk);
            check("ready_early", port_ready, 1'b0);
            repeat (scp_pkg::SETTLE_CYCLES - 2) @(posedge aclk);
            @(negedge aclk);
            check("ready_edge", port_ready, 1'b0);
            @(posedge aclk);
            @(negedge aclk);
            check("ready_late", port_ready, 1'b1);
         end
      join
      reg_is(4'h3, 8'h00);
      axi_read(scp_pkg::OFS_CTRL, rd, rsp);
      check("ctrl_reset", rd, 32'h00000004);
      axi_read(8'h30, rd, rsp);
      check("unmapped_rd", rsp, scp_pkg::RESP_SLVERR);
      axi_write(8'h34, 32'h000000FF, rsp);
      check("unmapped_wr", rsp, scp_pkg::RESP_SLVERR);
      scp_host_model_i.frame(cw(1'b0, 2'h0, 4'h5, 8'h3C), 15, rx);
      reg_is(4'h5, 8'h3C);
      scp_host_model_i.frame(cw(1'b0, 2'h0, 4'h9, 8'hC3) | 20'hF8000, 20, rx);
      reg_is(4'h9, 8'hC3);
      scp_host_model_i.frame(cw(1'b1, 2'h0, 4'h5, 8'hFF), 15, rx);
      reg_is(4'h5, 8'h3C);
      scp_host_model_i.frame(cw(1'b1, 2'h0, 4'h9, 8'h00), 15, rx);
      check("rd_back", rx, 8'h3C);
      scp_host_model_i.frame(cw(1'b0, 2'h0, 4'h2, 8'h81), 15, rx);
      check("rd_after_rd", rx, 8'hC3);
      scp_host_model_i.frame(cw(1'b1, 2'h0, 4'h0, 8'h00), 15, rx);
      check("rd_after_wr", rx, 8'h81);
      axi_read(scp_pkg::OFS_LAST, rd, rsp);
      check("last_word", rd, 32'h00004000);
      axi_read(scp_pkg::OFS_STATUS, rd, rsp);
      check("status", rd, 32'h00060001);
      fork
         scp_host_model_i.frame(cw(1'b0, 2'h1, 4'h5, 8'h77), 15, rx);
         begin
            repeat (20) @(posedge aclk);
            check("so_en_frame", serial_out_en_n, 1'b0);
         end
      join
      check("so_en_idle", serial_out_en_n, 1'b1);
      reg_is(4'h5, 8'h3C);
      for (int n = 0; n < 16; n++) begin
         axi_write(scp_pkg::OFS_REG0 + 8'(4 * n), {24'h000000, 4'(n), ~4'(n)}, rsp);
         check("axi_wr", rsp, scp_pkg::RESP_OKAY);
      end
      scp_host_model_i.frame(cw(1'b1, 2'h0, 4'h0, 8'h00), 15, rx);
      for (int n = 1; n <= 16; n++) begin
         scp_host_model_i.frame(cw(1'b1, 2'h0, 4'(n), 8'h00), 15, rx);
         check("rd_sweep", rx, {4'(n - 1), ~4'(n - 1)});
      end
      axi_write(scp_pkg::OFS_CTRL, 32'h00000001, rsp);
      axi_read(scp_pkg::OFS_CTRL, rd, rsp);
      check("ctrl_wr", rd, 32'h00000001);
      fork
         scp_host_model_i.frame(cw(1'b0, 2'h1, 4'h7, 8'h5A), 15, rx);
         begin
            repeat (20) @(posedge aclk);
            check("so_en_off", serial_out_en_n, 1'b1);
         end
      join
      axi_write(scp_pkg::OFS_CTRL, 32'h00000004, rsp);
      scp_host_model_i.frame(cw(1'b1, 2'h0, 4'h7, 8'h00), 15, rx);
      check("rd_other_unit", rx, 8'h00);
      reg_is(4'h7, 8'h5A);
      test_done();
   end
endmodule // tb
`default_nettype wire
